// ==== include/rot_setbit_pkg.sv ====
package rot_setbit_pkg;
  localparam int DATA_W = 8;
  localparam int BIT_ADDR_W = 8;
  localparam logic [7:0] OP_ROTATE_RIGHT_CARRY = 8'h13;
  localparam logic [7:0] OP_SET_CARRY = 8'hd3;
  localparam logic [7:0] OP_SET_DIRECT_BIT = 8'hd2;
  // bit addresses from here through 97 hex hit the port one output latch
  localparam logic [7:0] PORT_ONE_BIT_BASE = 8'h90;
  localparam logic [2:0] BIT_SEL_MSB = 3'h7;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam int BIT_SEL_W = 3;
  localparam int RAM_IDX_W = 6;
  localparam int PORT_BITS = 8;
  localparam int RAM_BITS = 64;
  localparam int ACC_LSB = 0;
  localparam logic [1:0] RAM_AREA_TAG = 2'h0;
  localparam logic [7:0] DIRECT_RESET = 8'h00;
  localparam logic [2:0] DIRECT_BYTES = 3'h7;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] bit_addr;
  } instr_type;

  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic [7:0] port_one;
  } arch_type;
endpackage

// ==== design/rot_setbit_exec.sv ====
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RQ1: rotate moves accumulator bit n+1 to n
// RQ2: old carry to bit 7, bit 0 to carry
// RQ3: opcode 13 is rotate, one cycle
// RQ4: set-bit forces carry or addressed bit high
// RQ5: set-bit leaves other flags untouched
// RQ6: opcode d3 sets carry, one cycle
// RQ7: port latch set changes only that bit
module rot_setbit_exec (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire rot_setbit_pkg::instr_type INSTR_I,
  input wire logic [7:0] ACC_LOAD_I,
  input wire logic ACC_LOAD_EN_I,
  input wire logic CARRY_LOAD_I,
  input wire logic CARRY_LOAD_EN_I,
  output rot_setbit_pkg::arch_type STATE_O,
  output logic [63:0] DIRECT_BITS_O,
  output logic DONE_O,
  output logic ILLEGAL_O
);
  import rot_setbit_pkg::*;

  ////////////////////////////////////////////////////////////////
  // types

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_RESET = 2'b10
  } phase_type;

  typedef struct packed {
    phase_type phase;
    arch_type arch;
    logic [RAM_BITS-1:0] direct;
    logic done;
    logic illegal;
  } state_type;

  typedef struct packed {
    logic rotate;
    logic set_carry;
    logic set_direct;
    logic known;
    logic in_port;
    logic in_ram;
  } decode_type;

  typedef struct packed {
    logic meta;
    logic sync;
  } rst_sync_type;

  ////////////////////////////////////////////////////////////////
  // registers and their combinational copies

  state_type s_reg;
  state_type s_next;
  rst_sync_type rst_reg;

  ////////////////////////////////////////////////////////////////
  // datapath wires

  decode_type dec;
  logic [DATA_W-1:0] acc_rotated;
  logic carry_rotated;
  logic [DATA_W-1:0] acc_loaded;
  logic carry_loaded;
  logic [BIT_SEL_W-1:0] port_sel;
  logic [RAM_IDX_W-1:0] ram_sel;
  logic [PORT_BITS-1:0] port_hit;
  logic [PORT_BITS-1:0] port_set;
  logic [RAM_BITS-1:0] ram_hit;
  logic [RAM_BITS-1:0] ram_set;

  ////////////////////////////////////////////////////////////////
  // reset release through two flip-flops

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_reg <= '0;
    end else begin
      rst_reg.meta <= 1'b1;
      rst_reg.sync <= rst_reg.meta;
    end
  end

  ////////////////////////////////////////////////////////////////
  // opcode and bit address decode

  always_comb begin
    dec = '0;
    case (INSTR_I.opcode)
      OP_ROTATE_RIGHT_CARRY: begin
        dec.rotate = INSTR_I.valid; // [RQ3]
      end
      OP_SET_CARRY: begin
        dec.set_carry = INSTR_I.valid; // [RQ6]
      end
      OP_SET_DIRECT_BIT: begin
        dec.set_direct = INSTR_I.valid; // [RQ4]
      end
      default: begin
        dec.rotate = 1'b0;
      end
    endcase
    dec.known = dec.rotate || dec.set_carry || dec.set_direct;
    dec.in_port = INSTR_I.bit_addr[BIT_ADDR_W-1:BIT_SEL_W] == PORT_ONE_BIT_BASE[BIT_ADDR_W-1:BIT_SEL_W]; // [RQ7]
    dec.in_ram = INSTR_I.bit_addr[BIT_ADDR_W-1:RAM_IDX_W] == RAM_AREA_TAG; // [RQ4]
  end

  assign port_sel = INSTR_I.bit_addr[BIT_SEL_W-1:0];
  assign ram_sel = INSTR_I.bit_addr[RAM_IDX_W-1:0];

  ////////////////////////////////////////////////////////////////
  // rotate right through carry, one wire per bit

  for (genvar n = 0; n < DATA_W - 1; n++) begin : g_rotate
    assign acc_rotated[n] = s_reg.arch.acc[n + 1]; // [RQ1]
  end

  assign acc_rotated[DATA_W-1] = s_reg.arch.carry; // [RQ2]
  assign carry_rotated = s_reg.arch.acc[ACC_LSB]; // [RQ2]

  ////////////////////////////////////////////////////////////////
  // core write path, lower priority than instruction results

  for (genvar n = 0; n < DATA_W; n++) begin : g_acc_load
    assign acc_loaded[n] = ACC_LOAD_EN_I ? ACC_LOAD_I[n] : s_reg.arch.acc[n];
  end

  assign carry_loaded = CARRY_LOAD_EN_I ? CARRY_LOAD_I : s_reg.arch.carry;

  ////////////////////////////////////////////////////////////////
  // port one latch bits, each set only by its own address

  for (genvar k = 0; k < PORT_BITS; k++) begin : g_port
    assign port_hit[k] = dec.set_direct && dec.in_port && (port_sel == BIT_SEL_W'(k)); // [RQ7]
    assign port_set[k] = s_reg.arch.port_one[k] | port_hit[k]; // [RQ7]
  end

  ////////////////////////////////////////////////////////////////
  // bit-addressable area, addresses above it are ignored

  for (genvar j = 0; j < RAM_BITS; j++) begin : g_ram
    assign ram_hit[j] = dec.set_direct && dec.in_ram && (ram_sel == RAM_IDX_W'(j)); // [RQ4]
    assign ram_set[j] = s_reg.direct[j] | ram_hit[j]; // [RQ4] [RQ5]
  end

  ////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.illegal = 1'b0;
    case (s_reg.phase)
      ST_RESET: begin
        s_next.phase = ST_RUN;
      end
      ST_RUN: begin
        s_next.arch.acc = acc_loaded;
        s_next.arch.carry = carry_loaded;
        s_next.arch.port_one = port_set; // [RQ7]
        s_next.direct = ram_set; // [RQ4]
        if (dec.rotate) begin // [RQ3]
          s_next.arch.acc = acc_rotated; // [RQ1] [RQ2]
          s_next.arch.carry = carry_rotated; // [RQ2]
        end
        if (dec.set_carry) begin // [RQ6]
          s_next.arch.carry = 1'b1; // [RQ4] [RQ5]
        end
        s_next.done = dec.known; // [RQ3] [RQ6]
        s_next.illegal = INSTR_I.valid && !dec.known;
      end
      default: begin
        s_next.phase = ST_RESET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CLK_I or negedge rst_reg.sync) begin
    if (!rst_reg.sync) begin
      s_reg.phase <= ST_RESET;
      s_reg.arch.acc <= ACC_RESET;
      s_reg.arch.carry <= 1'b0;
      s_reg.arch.port_one <= PORT_RESET;
      s_reg.direct <= '0;
      s_reg.done <= 1'b0;
      s_reg.illegal <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign STATE_O = s_reg.arch;
  assign DIRECT_BITS_O = s_reg.direct;
  assign DONE_O = s_reg.done;
  assign ILLEGAL_O = s_reg.illegal;

  ////////////////////////////////////////////////////////////////

endmodule // rot_setbit_exec
`default_nettype wire

// ==== verif/rsb_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module rsb_props (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire rot_setbit_pkg::instr_type INSTR_I,
  input wire rot_setbit_pkg::arch_type STATE_O,
  input wire logic [63:0] DIRECT_BITS_O,
  input wire logic DONE_O,
  input wire logic ILLEGAL_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  wire logic [7:0] o = INSTR_I.valid ? INSTR_I.opcode : 8'h0, a = STATE_O.acc, p = STATE_O.port_one;
  wire logic [7:0] b = INSTR_I.bit_addr;
  wire logic c = STATE_O.carry;
  rot_low_a: assert property (o == 8'h13 |=> a[6:0] == $past(a[7:1])) else $error("low");
  rot_wrap_a: assert property (o == 8'h13 |=> a[7] == $past(c) && c == $past(a[0])) else $error("wrap");
  rot_done_a: assert property (o == 8'h13 |=> DONE_O) else $error("done");
  set_carry_a: assert property (o == 8'hd3 |=> c) else $error("set");
  set_keep_a: assert property (o == 8'hd3 |=> $stable(a) && $stable(p)) else $error("keep");
  set_done_a: assert property (o == 8'hd3 |=> DONE_O) else $error("done");
  port_bit_a: assert property (o == 8'hd2 && b[7:3] == 5'h12 |=>
    p == ($past(p) | 8'h1 << $past(b[2:0]))) else $error("port");
  ram_bit_a: assert property (o == 8'hd2 && b[7:6] == 2'h0 |=> DIRECT_BITS_O[$past(b[5:0])]) else $error("ram");
  ram_gap_a: assert property (o == 8'hd2 && b[7:6] == 2'h1 |=> $stable(DIRECT_BITS_O) && $stable(p))
    else $error("gap");
  bad_op_a: assert property (INSTR_I.valid && !(o inside {8'h13, 8'hd3, 8'hd2}) |=>
    ILLEGAL_O && !DONE_O && $stable(p) && $stable(DIRECT_BITS_O)) else $error("illegal");
endmodule // rsb_props
bind rot_setbit_exec rsb_props rsb_props_inst (.CLK_I, .RESET_N_I, .INSTR_I, .STATE_O, .DIRECT_BITS_O, .DONE_O,
  .ILLEGAL_O);
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rot_setbit_pkg::*;
  logic clk = 0, rn = 0, ld = 1;
  instr_type ins = '0;
  arch_type st;
  logic [63:0] ram;
  logic done, bad;
  int fails = 0, tests_run = 0, cyc = 0;
  // rows: opcode, bit address, done and illegal pulses, acc, carry, port one
  logic [39:0] rows [6] = '{'h1300262100, 'h13002b1000, 'hd3002b1100, 'hd2902b1101, 'hd2452b1101, 'h00001b1101};
  rot_setbit_exec rot_setbit_exec_inst (.CLK_I(clk), .RESET_N_I(rn), .INSTR_I(ins), .ACC_LOAD_I(8'hc5),
    .ACC_LOAD_EN_I(ld), .CARRY_LOAD_I(1'b0), .CARRY_LOAD_EN_I(ld), .STATE_O(st), .DIRECT_BITS_O(ram),
    .DONE_O(done), .ILLEGAL_O(bad));
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (++cyc > 400) summarize();
  task chk(string n, logic [63:0] e, g);
    tests_run++;
    if (e !== g) begin
      fails++;
      $display("mismatch %s %h %h", n, e, g);
    end
  endtask
  task automatic run(logic [15:0] i);
    ins = {1'b1, i};
    @(posedge clk);
    #1;
  endtask
  task summarize;
    fails += cyc > 400;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rn = 1;
    repeat (4) @(posedge clk);
    #1 ld = 0;
    foreach (rows[k]) begin
      run(rows[k][39:24]);
      chk("state", rows[k][19:0], {st.acc, 3'h0, st.carry, st.port_one});
      chk("pulse", rows[k][21:20], {done, bad});
    end
    chk("ram", 64'h0, ram);
    run(16'hd205);
    chk("ram", 64'h20, ram);
    chk("state", 20'hb1101, {st.acc, 3'h0, st.carry, st.port_one});
    run(16'hd297);
    chk("port", 8'h81, st.port_one);
    chk("ram", 64'h20, ram);
    ins = '0;
    rn = 0;
    #1 chk("reset", {ACC_RESET, 4'h0, PORT_RESET}, {st.acc, 3'h0, st.carry, st.port_one});
    chk("reset_ram", 64'h0, ram);
    chk("reset_pulse", 2'h0, {done, bad});
    @(posedge clk);
    #1 rn = 1;
    repeat (3) @(posedge clk);
    #1;
    run(16'hd300);
    chk("carry", {ACC_RESET, 4'h1, PORT_RESET}, {st.acc, 3'h0, st.carry, st.port_one});
    summarize();
  end
endmodule // tb_top
`default_nettype wire
